// ===== core/swlm_crc16.sv
`timescale 1ns/1ps
`default_nettype none
module swlm_crc16
   import swlm_pkg::*;
(
   input  wire logic        i_mclk,
   input  wire logic        i_rst_n,
   input  wire logic        i_clear,
   input  wire logic        i_load,
   input  wire logic [15:0] i_load_val,
   input  wire logic        i_shift,
   input  wire logic        i_bit,
   output var  logic [15:0] o_crc
);
   logic [15:0] crc_nxt;
   wire         fb = o_crc[0] ^ i_bit;

   // Clear and load take priority over a shift
   always_comb begin
      crc_nxt = o_crc;
      if (i_clear) begin
         crc_nxt = CRC_CLEAR;
      end else if (i_load) begin
         crc_nxt = i_load_val;
      end else if (i_shift) begin
         crc_nxt = (o_crc >> 1) ^ (fb ? CRC_POLY_REFL : CRC_CLEAR);
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_crc <= CRC_CLEAR;
      end else begin
         o_crc <= crc_nxt;
      end
   end
endmodule : swlm_crc16
`default_nettype wire

// ===== core/swlm_master.sv
`timescale 1ns/1ps
`default_nettype none
module swlm_master
   import swlm_pkg::*;
(
   input  wire logic        i_mclk,
   input  wire logic        i_rst_n,
   // Command port
   input  wire logic        i_cmd_valid,
   input  wire logic [1:0]  i_cmd,
   input  wire logic        i_wr_bit,
   output var  logic        o_cmd_ready,
   output var  logic        o_done,
   output var  logic        o_rd_bit,
   output var  logic        o_presence,
   // CRC model controls, follow each write byte
   input  wire logic        i_crc_clear,
   input  wire logic        i_crc_load,
   input  wire logic [15:0] i_crc_load_addr,
   input  wire logic        i_crc_shift_en,
   input  wire logic        i_addr_high,
   input  wire logic        i_low_pullup_voltage,
   input  wire logic [15:0] i_crc_rx,
   input  wire logic        i_crc_check,
   output var  logic        o_crc_ok,
   output var  logic        o_crc_valid,
   // Line pins
   input  wire logic        i_line,
   output var  logic        o_line_out,
   output var  logic        o_line_oe,
   output var  logic        o_prog_en
);
   swlm_state_type        state_r;
   swlm_state_type        state_nxt;
   logic [TIMER_W-1:0]    timer_r;
   logic [TIMER_W-1:0]    low_len_r;
   logic [TIMER_W-1:0]    sample_at_r;
   logic                  is_read_r;
   logic                  sync1_r;
   logic                  sync2_r;
   logic                  sampled_r;
   logic                  oe_r;
   logic                  prog_r;
   logic                  ready_r;
   logic                  done_r;
   logic                  rd_bit_r;
   logic                  pres_r;
   logic                  crc_ok_r;
   logic                  crc_val_r;
   logic [15:0]           crc_val;

   function automatic logic [TIMER_W-1:0] cyc(input int unsigned c);
      return c[TIMER_W-1:0];
   endfunction : cyc

   wire start      = ready_r && i_cmd_valid;
   wire timer_last = (timer_r == {TIMER_W{1'b0}});
   wire elapsed_eq_sample;
   logic [TIMER_W-1:0] elapsed_r;
   assign elapsed_eq_sample = (elapsed_r == sample_at_r);

   // Shift bits are written bits; model mirrors slave high byte masking
   wire shift_bit  = i_wr_bit & (i_addr_high ? 1'b0 : 1'b1) | (i_wr_bit & ~i_addr_high);
   wire write_shift = start && (i_cmd == SWLM_CMD_WRITE) && i_crc_shift_en;

   // Slave forces high address top bits low; host mirrors it in the CRC model
   logic [3:0] bitpos_r;
   wire masked_bit = i_addr_high ? (i_wr_bit & ADDR_HIGH_KEEP_MASK[bitpos_r[2:0]]) : i_wr_bit;
   wire unused_ok  = shift_bit ^ i_low_pullup_voltage;

   swlm_crc16 u_crc (
      .i_mclk     (i_mclk),
      .i_rst_n    (i_rst_n),
      .i_clear    (i_crc_clear),
      .i_load     (i_crc_load),
      .i_load_val (i_crc_load_addr),
      .i_shift    (write_shift),
      .i_bit      (masked_bit),
      .o_crc      (crc_val)
   );

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         bitpos_r <= 4'h0;
      end else if (i_crc_clear || i_crc_load) begin
         bitpos_r <= 4'h0;
      end else if (write_shift) begin
         bitpos_r <= bitpos_r + 4'h1;
      end
   end

   // Line sampled through two flops
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         sync1_r <= 1'b1;
         sync2_r <= 1'b1;
      end else begin
         sync1_r <= i_line;
         sync2_r <= sync1_r;
      end
   end

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         SWLM_IDLE: begin
            if (start) begin
               case (i_cmd)
                  SWLM_CMD_RESET:   state_nxt = SWLM_RST_LOW;
                  SWLM_CMD_PROGRAM: state_nxt = SWLM_PRG_DELAY;
                  default:          state_nxt = SWLM_SLOT_LOW;
               endcase
            end
         end
         SWLM_RST_LOW:    if (timer_last) state_nxt = SWLM_RST_WAIT;
         SWLM_RST_WAIT:   if (timer_last) state_nxt = SWLM_RST_HIGH;
         SWLM_RST_HIGH:   if (timer_last) state_nxt = SWLM_IDLE;
         SWLM_SLOT_LOW:   if (timer_last) state_nxt = SWLM_SLOT_REL;
         SWLM_SLOT_REL:   if (timer_last) state_nxt = SWLM_SLOT_REC;
         SWLM_SLOT_REC:   if (timer_last) state_nxt = SWLM_IDLE;
         SWLM_PRG_DELAY:  if (timer_last) state_nxt = SWLM_PRG_PULSE;
         SWLM_PRG_PULSE:  if (timer_last) state_nxt = SWLM_PRG_VERIFY;
         SWLM_PRG_VERIFY: if (timer_last) state_nxt = SWLM_IDLE;
         default:         state_nxt = SWLM_IDLE;
      endcase
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_r <= SWLM_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Timer counts down to zero in each state; loaded on entry
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         timer_r     <= {TIMER_W{1'b0}};
         low_len_r   <= {TIMER_W{1'b0}};
         sample_at_r <= {TIMER_W{1'b0}};
         is_read_r   <= 1'b0;
      end else begin
         timer_r <= timer_last ? timer_r : timer_r - cyc(1);
         case (state_r)
            SWLM_IDLE: if (start) begin
               is_read_r <= (i_cmd == SWLM_CMD_READ);
               case (i_cmd)
                  SWLM_CMD_RESET:   timer_r <= cyc(RESET_LOW_CYC - 1);
                  SWLM_CMD_PROGRAM: timer_r <= cyc(PRE_PROGRAM_CYC - 1);
                  SWLM_CMD_READ: begin
                     timer_r     <= cyc(READ_START_LOW_CYC - 1);
                     low_len_r   <= cyc(READ_START_LOW_CYC);
                     sample_at_r <= cyc(READ_SAMPLE_CYC);
                  end
                  default: begin
                     timer_r     <= i_wr_bit ? cyc(ONE_BIT_LOW_CYC - 1)
                                             : cyc(ZERO_BIT_LOW_CYC - 1);
                     low_len_r   <= i_wr_bit ? cyc(ONE_BIT_LOW_CYC) : cyc(ZERO_BIT_LOW_CYC);
                     sample_at_r <= cyc(READ_SAMPLE_CYC);
                  end
               endcase
            end
            SWLM_RST_LOW:   if (timer_last) timer_r <= cyc(PRESENCE_SAMPLE_CYC - 1);
            SWLM_RST_WAIT:  if (timer_last) timer_r <= cyc(POST_RESET_HIGH_CYC - PRESENCE_SAMPLE_CYC - 1);
            SWLM_SLOT_LOW:  if (timer_last) timer_r <= cyc(SLOT_DURATION_CYC) - low_len_r - cyc(1);
            SWLM_SLOT_REL:  if (timer_last) timer_r <= cyc(SLOT_RECOVERY_CYC - 1);
            SWLM_PRG_DELAY: if (timer_last) timer_r <= cyc(PROGRAM_PULSE_CYC - 1);
            SWLM_PRG_PULSE: if (timer_last) timer_r <= cyc(PRE_VERIFY_CYC - 1);
            default: ;
         endcase
      end
   end

   // Elapsed time since the slot's falling edge
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         elapsed_r <= {TIMER_W{1'b0}};
         sampled_r <= 1'b1;
      end else if (state_r == SWLM_IDLE) begin
         elapsed_r <= {TIMER_W{1'b0}};
      end else begin
         elapsed_r <= elapsed_r + cyc(1);
         // Sync delay of two cycles is inside the sample margin
         if ((state_r == SWLM_SLOT_REL || state_r == SWLM_SLOT_LOW) && elapsed_eq_sample) begin
            sampled_r <= sync2_r;
         end
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         oe_r      <= 1'b0;
         prog_r    <= 1'b0;
         ready_r   <= 1'b1;
         done_r    <= 1'b0;
         rd_bit_r  <= 1'b1;
         pres_r    <= 1'b0;
         crc_ok_r  <= 1'b0;
         crc_val_r <= 1'b0;
      end else begin
         oe_r    <= (state_nxt == SWLM_RST_LOW) || (state_nxt == SWLM_SLOT_LOW);
         prog_r  <= (state_nxt == SWLM_PRG_PULSE);
         ready_r <= (state_nxt == SWLM_IDLE);
         done_r  <= (state_r != SWLM_IDLE) && (state_nxt == SWLM_IDLE);
         if (state_r == SWLM_SLOT_REC && timer_last && is_read_r) begin
            rd_bit_r <= sampled_r;
         end
         if (state_r == SWLM_RST_WAIT && timer_last) begin
            pres_r <= ~sync2_r;
         end
         crc_val_r <= i_crc_check;
         if (i_crc_check) begin
            // Slave returns the inverted CRC; decision to program stays outside
            crc_ok_r <= ((~i_crc_rx) == crc_val) ^ (unused_ok & 1'b0);
         end
      end
   end

   assign o_line_out  = 1'b0;
   assign o_line_oe   = oe_r;
   assign o_prog_en   = prog_r;
   assign o_cmd_ready = ready_r;
   assign o_done      = done_r;
   assign o_rd_bit    = rd_bit_r;
   assign o_presence  = pres_r;
   assign o_crc_ok    = crc_ok_r;
   assign o_crc_valid = crc_val_r;
endmodule : swlm_master
`default_nettype wire

// ===== core/swlm_pkg.sv
package swlm_pkg;
   localparam int unsigned CLK_MHZ = 20;

   // Times in microseconds
   localparam int unsigned RESET_LOW_US        = 480;
   localparam int unsigned POST_RESET_HIGH_US  = 480;
   localparam int unsigned PRESENCE_SAMPLE_US  = 70;
   localparam int unsigned SLOT_DURATION_US    = 70;
   localparam int unsigned ONE_BIT_LOW_US      = 6;
   localparam int unsigned ZERO_BIT_LOW_US     = 65;
   localparam int unsigned READ_START_LOW_US   = 1;
   localparam int unsigned READ_SAMPLE_US      = 13;
   localparam int unsigned SLOT_RECOVERY_US    = 5;
   localparam int unsigned PRE_PROGRAM_US      = 5;
   localparam int unsigned PROGRAM_PULSE_US    = 480;
   localparam int unsigned PRE_VERIFY_US       = 5;

   // Exact CLK_MHZ cycles per us; read start low is one cycle less
   function automatic int unsigned us_to_cyc(input int unsigned us);
      return us * CLK_MHZ;
   endfunction : us_to_cyc

   localparam int unsigned RESET_LOW_CYC       = us_to_cyc(RESET_LOW_US);
   localparam int unsigned POST_RESET_HIGH_CYC = us_to_cyc(POST_RESET_HIGH_US);
   localparam int unsigned PRESENCE_SAMPLE_CYC = us_to_cyc(PRESENCE_SAMPLE_US);
   localparam int unsigned SLOT_DURATION_CYC   = us_to_cyc(SLOT_DURATION_US);
   localparam int unsigned ONE_BIT_LOW_CYC     = us_to_cyc(ONE_BIT_LOW_US);
   localparam int unsigned ZERO_BIT_LOW_CYC    = us_to_cyc(ZERO_BIT_LOW_US);
   localparam int unsigned READ_START_LOW_CYC  = us_to_cyc(READ_START_LOW_US) - 1;
   localparam int unsigned READ_SAMPLE_CYC     = us_to_cyc(READ_SAMPLE_US);
   localparam int unsigned SLOT_RECOVERY_CYC   = us_to_cyc(SLOT_RECOVERY_US);
   localparam int unsigned PRE_PROGRAM_CYC     = us_to_cyc(PRE_PROGRAM_US);
   localparam int unsigned PROGRAM_PULSE_CYC   = us_to_cyc(PROGRAM_PULSE_US);
   localparam int unsigned PRE_VERIFY_CYC      = us_to_cyc(PRE_VERIFY_US);

   localparam int unsigned TIMER_W = 14;

   // CRC-16, polynomial x^16 + x^15 + x^2 + 1, reflected form
   localparam logic [15:0] CRC_POLY_REFL = 16'ha001;
   localparam logic [15:0] CRC_CLEAR     = 16'h0000;
   localparam logic [7:0]  ADDR_HIGH_KEEP_MASK = 8'h07;

   typedef enum logic [3:0] {
      SWLM_IDLE       = 4'h0,
      SWLM_RST_LOW    = 4'h1,
      SWLM_RST_WAIT   = 4'h3,
      SWLM_RST_HIGH   = 4'h2,
      SWLM_SLOT_LOW   = 4'h6,
      SWLM_SLOT_REL   = 4'h7,
      SWLM_SLOT_REC   = 4'h5,
      SWLM_PRG_DELAY  = 4'h4,
      SWLM_PRG_PULSE  = 4'hc,
      SWLM_PRG_VERIFY = 4'hd
   } swlm_state_type;

   typedef enum logic [1:0] {
      SWLM_CMD_RESET   = 2'h0,
      SWLM_CMD_WRITE   = 2'h1,
      SWLM_CMD_READ    = 2'h2,
      SWLM_CMD_PROGRAM = 2'h3
   } swlm_cmd_type;
endpackage : swlm_pkg

// ===== testbench/swlm_master_checker.sv
`timescale 1ns/1ps
`default_nettype none
module swlm_master_checker (
   input wire logic       i_mclk,
   input wire logic       i_rst_n,
   input wire logic       i_cmd_valid,
   input wire logic [1:0] i_cmd,
   input wire logic       i_wr_bit,
   input wire logic       i_crc_check,
   input wire logic       o_cmd_ready,
   input wire logic       o_done,
   input wire logic       o_line_oe,
   input wire logic       o_prog_en,
   input wire logic       o_crc_valid
);
   wire         acc = i_cmd_valid & o_cmd_ready;
   logic [1:0]  cmd_r;
   logic        bit_r;
   logic [14:0] lo_r, hi_r, st_r, pg_r, pf_r;
   // Saturate so long idle spans never wrap
   function automatic logic [14:0] inc(input logic [14:0] v, input logic c);
      return !c ? 15'h0000 : (&v ? v : v + 15'h0001);
   endfunction : inc
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cmd_r <= 2'h0;
         bit_r <= 1'b0;
         lo_r  <= 15'h0000;
         hi_r  <= 15'h7fff;
         st_r  <= 15'h0000;
         pg_r  <= 15'h0000;
         pf_r  <= 15'h7fff;
      end else begin
         cmd_r <= acc ? i_cmd : cmd_r;
         bit_r <= acc ? i_wr_bit : bit_r;
         lo_r  <= inc(lo_r, o_line_oe);
         hi_r  <= inc(hi_r, !o_line_oe);
         st_r  <= inc(st_r, !acc);
         pg_r  <= inc(pg_r, o_prog_en);
         pf_r  <= inc(pf_r, !o_prog_en);
      end
   end
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_rst_n);
   a_wr_one_low: assert property ($fell(o_line_oe) && cmd_r == 2'h1 && bit_r |-> lo_r inside {[20:300]})
      else $error("write one low time out of range");
   a_wr_zero_low: assert property ($fell(o_line_oe) && cmd_r == 2'h1 && !bit_r |-> lo_r inside {[1200:2400]})
      else $error("write zero low time out of range");
   a_rd_start_low: assert property ($fell(o_line_oe) && cmd_r == 2'h2 |-> lo_r inside {[1:20]})
      else $error("read start low time out of range");
   a_rst_low_time: assert property ($fell(o_line_oe) && cmd_r == 2'h0 |-> lo_r >= 15'd9600)
      else $error("reset low too short");
   a_slot_length: assert property (o_done && cmd_r inside {2'h1, 2'h2} |-> st_r inside {[1220:1510]})
      else $error("slot length out of range");
   a_slot_recovery: assert property ($rose(o_line_oe) |-> hi_r >= 15'd20)
      else $error("recovery before slot too short");
   a_post_rst_high: assert property (o_done && cmd_r == 2'h0 |-> hi_r >= 15'd9598 && o_cmd_ready)
      else $error("line high after reset too short");
   a_prog_delay: assert property ($rose(o_prog_en) |-> cmd_r == 2'h3 && hi_r >= 15'd100)
      else $error("program pulse started early");
   a_prog_width: assert property ($fell(o_prog_en) |-> pg_r >= 15'd9600 && !o_line_oe)
      else $error("program pulse too short");
   a_prog_verify: assert property (o_done && cmd_r == 2'h3 |-> pf_r >= 15'd100)
      else $error("verify delay after program too short");
   a_crc_answer: assert property (i_crc_check |-> ##[0:1] o_crc_valid)
      else $error("crc compare gave no answer");
endmodule : swlm_master_checker
`default_nettype wire

// ===== testbench/swlm_master_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module swlm_master_tb_top
   import swlm_pkg::*;
;
   typedef struct packed {logic [1:0] cmd; logic bt; logic slow; logic ex;} swlm_row_type;
   localparam swlm_row_type ROWS [4] = '{'{2'h0, 1'b0, 1'b1, 1'b1}, '{2'h1, 1'b1, 1'b0, 1'b0},
                                         '{2'h2, 1'b0, 1'b0, 1'b0}, '{2'h2, 1'b0, 1'b0, 1'b1}};
   logic        mclk = 0, rst_n = 0, cv = 0, wb = 0, cclr = 0, cld = 0, csh = 0, ahi = 0;
   logic        lowv = 0, cchk = 0, slow = 0, rd = 0;
   logic [1:0]  cmd = 2'h0;
   logic [15:0] cla = 16'h0000, crx = 16'h0000, exp;
   wire         ready, done, rbit, pres, cok, cval, lout, oe, prg;
   wire  [7:0]  wlog;
   tri1         line;
   int          n_errors = 0, samples_checked = 0;
   assign line = oe ? lout : 1'bz;
   always #25 mclk = ~mclk;
   swlm_master dut (.i_mclk(mclk), .i_rst_n(rst_n), .i_cmd_valid(cv), .i_cmd(cmd), .i_wr_bit(wb),
      .o_cmd_ready(ready), .o_done(done), .o_rd_bit(rbit), .o_presence(pres), .i_crc_clear(cclr),
      .i_crc_load(cld), .i_crc_load_addr(cla), .i_crc_shift_en(csh), .i_addr_high(ahi), .i_low_pullup_voltage(lowv),
      .i_crc_rx(crx), .i_crc_check(cchk), .o_crc_ok(cok), .o_crc_valid(cval), .i_line(line),
      .o_line_out(lout), .o_line_oe(oe), .o_prog_en(prg));
   swlm_slave_model bus (.io_line(line), .i_slow(slow), .i_rd(rd), .i_rd_pat(8'h02), .o_wr_log(wlog));
   task automatic chk(input logic [15:0] seen, input logic [15:0] want);
      samples_checked++;
      if (seen !== want) begin
         n_errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask : chk
   task automatic tally_and_finish();
      $display("mismatches %0d, comparisons %0d", n_errors, samples_checked);
      if (n_errors == 0 && samples_checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : tally_and_finish
   function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
      for (int k = 0; k < 8; k++) c = (c[0] ^ b[k]) ? ((c >> 1) ^ 16'ha001) : (c >> 1);
      return c;
   endfunction : crc_byte
   // Request held until the taking edge, then dropped
   task automatic op(input logic [1:0] c, input logic b, input logic sh, input logic hi);
      int n;
      @(posedge mclk);
      #2;
      {cv, cmd, wb, csh, ahi} = {1'b1, c, b, sh, hi};
      rd = (c == SWLM_CMD_READ);
      @(posedge mclk);
      #2;
      {cv, csh, ahi} = 3'h0;
      n = 0;
      while (done !== 1'b1 && n < 21000) begin
         @(posedge mclk);
         #1;
         n++;
      end
      chk(16'(done), 16'h0001);
   endtask : op
   task automatic pls(input logic [2:0] m);
      @(posedge mclk);
      #2;
      {cchk, cld, cclr} = m;
      @(posedge mclk);
      #2;
      {cchk, cld, cclr} = 3'h0;
   endtask : pls
   task automatic wbyte(input logic [7:0] b, input logic hi);
      for (int k = 0; k < 8; k++) op(SWLM_CMD_WRITE, b[k], 1'b1, hi);
   endtask : wbyte
   task automatic crc_cmp(input logic [15:0] rx, input logic want);
      int n;
      crx = rx;
      pls(3'b100);
      n = 0;
      while (cval !== 1'b1 && n < 4) begin
         @(posedge mclk);
         #1;
         n++;
      end
      chk(16'(cok), 16'(want));
   endtask : crc_cmp
   initial begin
      repeat (8) @(posedge mclk);
      chk({11'h0, oe, prg, ready, rbit, pres}, 16'h0006);
      #2 rst_n = 1;
      foreach (ROWS[i]) begin
         slow = ROWS[i].slow;
         op(ROWS[i].cmd, ROWS[i].bt, 1'b0, 1'b0);
         if (ROWS[i].cmd == SWLM_CMD_RESET) chk(16'(pres), 16'(ROWS[i].ex));
         if (ROWS[i].cmd == SWLM_CMD_READ) chk(16'(rbit), 16'(ROWS[i].ex));
      end
      lowv = 1;
      pls(3'b001);
      wbyte(8'h0f, 1'b0);
      wbyte(8'h10, 1'b0);
      wbyte(8'hf8, 1'b1);
      wbyte(8'ha5, 1'b0);
      chk(16'(wlog), 16'h00a5);
      exp = crc_byte(crc_byte(crc_byte(crc_byte(16'h0000, 8'h0f), 8'h10), 8'h00), 8'ha5);
      crc_cmp(~exp, 1'b1);
      cla = 16'h0011;
      pls(3'b010);
      wbyte(8'h3c, 1'b0);
      exp = crc_byte(16'h0011, 8'h3c);
      crc_cmp(~exp, 1'b1);
      crc_cmp(exp, 1'b0);
      // Bad CRC seen, programming still allowed: the decision stays in software
      op(SWLM_CMD_PROGRAM, 1'b0, 1'b0, 1'b0);
      chk({14'h0, prg, ready}, 16'h0001);
      tally_and_finish();
   end
   initial begin
      repeat (98000) @(posedge mclk);
      n_errors++;
      tally_and_finish();
   end
endmodule : swlm_master_tb_top
bind swlm_master swlm_master_checker chk_u (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_cmd_valid(i_cmd_valid),
   .i_cmd(i_cmd), .i_wr_bit(i_wr_bit), .i_crc_check(i_crc_check), .o_cmd_ready(o_cmd_ready), .o_done(o_done),
   .o_line_oe(o_line_oe), .o_prog_en(o_prog_en), .o_crc_valid(o_crc_valid));
`default_nettype wire

// ===== testbench/swlm_slave_model.sv
`timescale 1ns/1ps
`default_nettype none
module swlm_slave_model (
   inout  tri1             io_line,
   input  wire logic       i_slow,
   input  wire logic       i_rd,
   input  wire logic [7:0] i_rd_pat,
   output var  logic [7:0] o_wr_log
);
   logic       drv = 1'b0;
   logic [2:0] ri = 3'h0;
   logic [7:0] wlog_r = 8'h00;
   realtime    t_fall;
   assign io_line = drv ? 1'b0 : 1'bz;
   assign o_wr_log = wlog_r;
   // No clock of its own: slot timing hangs off the falling edge, the presence pulse off the line's release
   always @(negedge io_line) begin
      t_fall = $realtime;
      if (i_rd) begin
         if (!i_rd_pat[ri]) begin
            #500 drv = 1'b1;
            #29500 drv = 1'b0;
         end
         ri = ri + 3'h1;
      end else begin
         #30000 wlog_r = {io_line, wlog_r[7:1]};
      end
      wait (io_line === 1'b1);
      if ($realtime - t_fall > 120000.0) begin
         #(i_slow ? 55000 : 20000) drv = 1'b1;
         #(i_slow ? 200000 : 100000) drv = 1'b0;
         ri = 3'h0;
      end
   end
endmodule : swlm_slave_model
`default_nettype wire
